// ---- pwl_defines.vh ----
// constants for the periodic wakeup timer and low-voltage control bank
`ifndef PWL_DEFINES_VH
`define PWL_DEFINES_VH

// avalon byte addresses of the three registers
`define PWL_ADDR_WAKEUP      4'h0
`define PWL_ADDR_POWER       4'h4
`define PWL_ADDR_PENDING     4'h8

// wakeup_timer_status_control fields
`define PWL_WK_FLAG          7
`define PWL_WK_ACK           6
`define PWL_WK_CLK_SEL       5
`define PWL_WK_IRQ_EN        4
`define PWL_WK_PER_HI        2
`define PWL_WK_PER_LO        0

// power_monitor_status_control fields
`define PWL_LV_FLAG          7
`define PWL_LV_ACK           6
`define PWL_LV_IRQ_EN        5
`define PWL_LV_RST_EN        4
`define PWL_LV_STOP_EN       3
`define PWL_LV_MASTER_EN     2
`define PWL_LV_BGAP_EN       0

// interrupt_pending_summary field
`define PWL_PEND_WAKEUP      0

// reset values
`define PWL_WK_RESET         8'h00
`define PWL_LV_RESET         8'h00
`define PWL_PER_OFF          3'h0

// timing: reference clock and internal oscillator periods
`define PWL_REF_CLK_NS       40
`define PWL_LPO_PERIOD_NS    1000000
`define PWL_LPO_PERIOD_US    1000

// timeouts on the internal oscillator, in ms
`define PWL_TMO_MS_1         8
`define PWL_TMO_MS_2         32
`define PWL_TMO_MS_3         64
`define PWL_TMO_MS_4         128
`define PWL_TMO_MS_5         256
`define PWL_TMO_MS_6         512
`define PWL_TMO_MS_7         1024

// timeouts on the external clock, in external periods
`define PWL_TMO_EXT_1        256
`define PWL_TMO_EXT_2        1024
`define PWL_TMO_EXT_3        2048
`define PWL_TMO_EXT_4        4096
`define PWL_TMO_EXT_5        8192
`define PWL_TMO_EXT_6        16384
`define PWL_TMO_EXT_7        32768

`endif

// ---- pwl_wakeup_timer.v ----
// wakeup timer counter with period decode for both clock sources
`include "pwl_defines.vh"

module pwl_wakeup_timer #(
  parameter CNT_W = 16
) (
  input  wire             ref_clk,
  input  wire             resetn,
  input  wire             tick,
  input  wire             clk_sel,
  input  wire [2:0]       period_sel,
  output reg              timeout_r
);

  // ms figures converted to 1 kHz ticks
  localparam integer K1 = `PWL_TMO_MS_1 * 1000 / `PWL_LPO_PERIOD_US;
  localparam integer K2 = `PWL_TMO_MS_2 * 1000 / `PWL_LPO_PERIOD_US;
  localparam integer K3 = `PWL_TMO_MS_3 * 1000 / `PWL_LPO_PERIOD_US;
  localparam integer K4 = `PWL_TMO_MS_4 * 1000 / `PWL_LPO_PERIOD_US;
  localparam integer K5 = `PWL_TMO_MS_5 * 1000 / `PWL_LPO_PERIOD_US;
  localparam integer K6 = `PWL_TMO_MS_6 * 1000 / `PWL_LPO_PERIOD_US;
  localparam integer K7 = `PWL_TMO_MS_7 * 1000 / `PWL_LPO_PERIOD_US;

  // terminal counts, cut on purpose to the counter width below
  localparam [31:0] L1 = K1 - 1;
  localparam [31:0] L2 = K2 - 1;
  localparam [31:0] L3 = K3 - 1;
  localparam [31:0] L4 = K4 - 1;
  localparam [31:0] L5 = K5 - 1;
  localparam [31:0] L6 = K6 - 1;
  localparam [31:0] L7 = K7 - 1;
  localparam [31:0] E1 = `PWL_TMO_EXT_1 - 1;
  localparam [31:0] E2 = `PWL_TMO_EXT_2 - 1;
  localparam [31:0] E3 = `PWL_TMO_EXT_3 - 1;
  localparam [31:0] E4 = `PWL_TMO_EXT_4 - 1;
  localparam [31:0] E5 = `PWL_TMO_EXT_5 - 1;
  localparam [31:0] E6 = `PWL_TMO_EXT_6 - 1;
  localparam [31:0] E7 = `PWL_TMO_EXT_7 - 1;

  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] last_tick;

  // terminal count for the selected source and period
  always @* begin
    last_tick = {CNT_W{1'b1}};
    if (!clk_sel) begin
      case (period_sel)
        3'h1:    last_tick = L1[CNT_W-1:0];
        3'h2:    last_tick = L2[CNT_W-1:0];
        3'h3:    last_tick = L3[CNT_W-1:0];
        3'h4:    last_tick = L4[CNT_W-1:0];
        3'h5:    last_tick = L5[CNT_W-1:0];
        3'h6:    last_tick = L6[CNT_W-1:0];
        3'h7:    last_tick = L7[CNT_W-1:0];
        default: last_tick = {CNT_W{1'b1}};
      endcase
    end else begin
      case (period_sel)
        3'h1:    last_tick = E1[CNT_W-1:0];
        3'h2:    last_tick = E2[CNT_W-1:0];
        3'h3:    last_tick = E3[CNT_W-1:0];
        3'h4:    last_tick = E4[CNT_W-1:0];
        3'h5:    last_tick = E5[CNT_W-1:0];
        3'h6:    last_tick = E6[CNT_W-1:0];
        3'h7:    last_tick = E7[CNT_W-1:0];
        default: last_tick = {CNT_W{1'b1}};
      endcase
    end
  end

  // counter; code zero holds it cleared for either source
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r     <= {CNT_W{1'b0}};
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= 1'b0;
      if (period_sel == `PWL_PER_OFF) begin
        cnt_r <= {CNT_W{1'b0}};
      end else if (tick) begin
        if (cnt_r >= last_tick) begin
          cnt_r     <= {CNT_W{1'b0}};
          timeout_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

endmodule // pwl_wakeup_timer

// ---- pwl_ctrl.v ----
// wakeup timer and low-voltage control register bank on avalon-mm
`include "pwl_defines.vh"

module pwl_ctrl #(
  parameter LPO_DIV = `PWL_LPO_PERIOD_NS / `PWL_REF_CLK_NS
) (
  input  wire        ref_clk,
  input  wire        resetn,
  // avalon-mm slave
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output wire [31:0] readdata,
  output wire        waitrequest,
  // pins and neighbouring logic
  input  wire        ext_clk,
  input  wire        low_voltage_event,
  input  wire        stop_mode,
  output wire        wakeup_irq,
  output wire        low_voltage_irq,
  output wire        low_voltage_reset_req,
  output wire        low_voltage_detect_on,
  output wire        bandgap_buffer_enable
);

  // the divider compares in 16 bits; the default count fits with room
  localparam [31:0] LPO_LAST_W = LPO_DIV - 1;
  localparam [15:0] LPO_LAST   = LPO_LAST_W[15:0];

  // bus handshake state
  reg         ack_r;
  reg  [31:0] rdata_r;
  reg  [31:0] rdata_nxt;

  // wakeup register fields
  reg         wk_flag_r;
  reg         wk_flag_nxt;
  reg         wk_clk_sel_r;
  reg         wk_irq_en_r;
  reg  [2:0]  wk_period_r;

  // power monitor register fields
  reg         lv_flag_r;
  reg         lv_flag_nxt;
  reg         lv_irq_en_r;
  reg         lv_rst_en_r;
  reg         lv_stop_en_r;
  reg         lv_master_r;
  reg         lv_bgap_r;
  reg         lv_once_r;

  // synchronisers and dividers
  reg  [2:0]  ext_sync_r;
  reg  [1:0]  lv_sync_r;
  reg  [15:0] lpo_cnt_r;
  reg         lpo_tick_r;

  // bus decode
  wire        req;
  wire        wr_go;
  wire        rd_go;
  wire        hit_wk;
  wire        hit_lv;
  wire        wr_wk;
  wire        wr_lv;
  wire        wk_ack_wr;
  wire        lv_ack_wr;

  // timer and detector paths
  wire        ext_rise;
  wire        timer_tick;
  wire        timeout;
  wire        lv_event_s;
  wire        lv_active;

  // register views
  wire [7:0]  wk_view;
  wire [7:0]  lv_view;
  wire [7:0]  pend_view;

  // one wait state: every request is answered on its second edge
  assign req         = read | write;
  assign waitrequest = req & ~ack_r;
  assign wr_go       = write & ack_r;
  assign rd_go       = read & ~ack_r;
  assign readdata    = rdata_r;

  // address hits; the pending register is read-only, and anything else falls through to the zero read
  assign hit_wk = (address == `PWL_ADDR_WAKEUP);
  assign hit_lv = (address == `PWL_ADDR_POWER);

  // writes need byte lane 0, where the eight register bits sit
  assign wr_wk = wr_go & byteenable[0] & hit_wk;
  assign wr_lv = wr_go & byteenable[0] & hit_lv;

  // acknowledge strobes: a written one clears, a written zero is ignored
  assign wk_ack_wr = wr_wk & writedata[`PWL_WK_ACK];
  assign lv_ack_wr = wr_lv & writedata[`PWL_LV_ACK];

  // ack lasts one cycle, so a request still held after its answer
  // is seen as a fresh one; the master must drop it at the answer edge
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // register views; ack bits and unused bits read as zero
  assign wk_view = {wk_flag_r, 1'b0, wk_clk_sel_r, wk_irq_en_r,
                    1'b0, wk_period_r};
  assign lv_view = {lv_flag_r, 1'b0, lv_irq_en_r, lv_rst_en_r,
                    lv_stop_en_r, lv_master_r, 1'b0, lv_bgap_r};
  assign pend_view = {7'h00, wk_flag_r & wk_irq_en_r};

  // read mux; unmapped addresses read zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (address)
      `PWL_ADDR_WAKEUP:  rdata_nxt = {24'h00_0000, wk_view};
      `PWL_ADDR_POWER:   rdata_nxt = {24'h00_0000, lv_view};
      `PWL_ADDR_PENDING: rdata_nxt = {24'h00_0000, pend_view};
      default:           rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data is captured on the first edge, shown with waitrequest low
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_r <= rdata_nxt;
    end
  end

  // external clock pin: two flops, then a third for edge detection;
  // the pin must run below half of ref_clk to be seen
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_clk};
    end
  end

  // detector output comes from the analog side, so two flops as well
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lv_sync_r <= 2'h0;
    end else begin
      lv_sync_r <= {lv_sync_r[0], low_voltage_event};
    end
  end

  // only the second flop is read; the first may still be settling
  assign lv_event_s = lv_sync_r[1];

  assign ext_rise = ext_sync_r[1] & ~ext_sync_r[2];

  // 1 kHz enable pulse stands in for the internal oscillator; it is
  // exact, where a real low-power oscillator would drift with supply
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lpo_cnt_r  <= 16'h0000;
      lpo_tick_r <= 1'b0;
    end else if (lpo_cnt_r >= LPO_LAST) begin
      lpo_cnt_r  <= 16'h0000;
      lpo_tick_r <= 1'b1;
    end else begin
      lpo_cnt_r  <= lpo_cnt_r + 16'h0001;
      lpo_tick_r <= 1'b0;
    end
  end

  // source select for the timer
  assign timer_tick = wk_clk_sel_r ? ext_rise : lpo_tick_r;

  pwl_wakeup_timer #(
    .CNT_W      (16)
  ) u_timer (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .tick       (timer_tick),
    .clk_sel    (wk_clk_sel_r),
    .period_sel (wk_period_r),
    .timeout_r  (timeout)
  );

  // wakeup flag: a timeout in the ack cycle still sets the flag
  always @* begin
    wk_flag_nxt = wk_flag_r;
    if (wk_ack_wr) begin
      wk_flag_nxt = 1'b0;
    end
    if (timeout) begin
      wk_flag_nxt = 1'b1;
    end
  end

  // wakeup flag register
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wk_flag_r <= 1'b0;
    end else begin
      wk_flag_r <= wk_flag_nxt;
    end
  end

  // wakeup control fields, plain read/write
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wk_clk_sel_r <= 1'b0;
      wk_irq_en_r  <= 1'b0;
      wk_period_r  <= `PWL_PER_OFF;
    end else if (wr_wk) begin
      wk_clk_sel_r <= writedata[`PWL_WK_CLK_SEL];
      wk_irq_en_r  <= writedata[`PWL_WK_IRQ_EN];
      wk_period_r  <= writedata[`PWL_WK_PER_HI:`PWL_WK_PER_LO];
    end
  end

  // detection runs when enabled, and in stop only if allowed
  assign lv_active = lv_master_r & (~stop_mode | lv_stop_en_r);

  // low-voltage flag: a detect event wins over an ack in the same cycle
  always @* begin
    lv_flag_nxt = lv_flag_r;
    if (lv_ack_wr) begin
      lv_flag_nxt = 1'b0;
    end
    if (lv_active && lv_event_s) begin
      lv_flag_nxt = 1'b1;
    end
  end

  // low-voltage flag register
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lv_flag_r <= 1'b0;
    end else begin
      lv_flag_r <= lv_flag_nxt;
    end
  end

  // plain read/write power fields
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lv_irq_en_r  <= 1'b0;
      lv_stop_en_r <= 1'b0;
      lv_bgap_r    <= 1'b0;
    end else if (wr_lv) begin
      lv_irq_en_r  <= writedata[`PWL_LV_IRQ_EN];
      lv_stop_en_r <= writedata[`PWL_LV_STOP_EN];
      lv_bgap_r    <= writedata[`PWL_LV_BGAP_EN];
    end
  end

  // write-once group: the first lane-0 write after reset locks both bits,
  // whatever it carries, so stray code cannot arm a reset later
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lv_rst_en_r <= 1'b0;
      lv_master_r <= 1'b0;
      lv_once_r   <= 1'b0;
    end else if (wr_lv) begin
      lv_once_r <= 1'b1;
      if (!lv_once_r) begin
        lv_rst_en_r <= writedata[`PWL_LV_RST_EN];
        lv_master_r <= writedata[`PWL_LV_MASTER_EN];
      end
    end
  end

  // outputs: requests are levels that follow the flags
  assign wakeup_irq            = wk_flag_r & wk_irq_en_r;

  // low-voltage requests need the master enable even with the flag set
  assign low_voltage_irq       = lv_flag_r & lv_irq_en_r
                                 & lv_master_r;
  assign low_voltage_reset_req = lv_flag_r & lv_rst_en_r
                                 & lv_master_r;

  // detector power follows master enable and stop permission
  assign low_voltage_detect_on = lv_active;
  // the buffer also serves the comparator, so it is not tied to master
  assign bandgap_buffer_enable = lv_bgap_r;

endmodule // pwl_ctrl

// ---- pwl_ctrl_sva.sv ----
// port-level concurrent checks for the wakeup and low-voltage register bank
`include "pwl_defines.vh"
module pwl_ctrl_sva (
  input logic        ref_clk,
  input logic        resetn,
  input logic [3:0]  address,
  input logic        read,
  input logic        write,
  input logic [31:0] readdata,
  input logic        waitrequest,
  input logic        stop_mode,
  input logic        wakeup_irq,
  input logic        low_voltage_irq,
  input logic        low_voltage_reset_req,
  input logic        low_voltage_detect_on,
  input logic        bandgap_buffer_enable
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // completed reads per register; readdata mirrors the regs of the prior cycle
  wire rd_done = read && !waitrequest;
  wire rd_wk   = rd_done && address == `PWL_ADDR_WAKEUP;
  wire rd_lv   = rd_done && address == `PWL_ADDR_POWER;
  wire rd_pd   = rd_done && address == `PWL_ADDR_PENDING;

  a_one_wait: assert property ($rose(read || write) |->
    waitrequest ##1 !waitrequest) else $error("wait state count wrong");
  a_wk_ack_zero: assert property (rd_wk |->
    !readdata[6] && !readdata[3]) else $error("wakeup ack or bit3 set");
  a_lv_ack_zero: assert property (rd_lv |->
    !readdata[6] && !readdata[1]) else $error("lv ack or bit1 set");
  a_unmapped_zero: assert property (rd_done &&
    !(rd_wk || rd_lv || rd_pd) |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_pend_match: assert property (rd_pd |->
    readdata == {31'h0, $past(wakeup_irq)}) else $error("pending mismatch");
  a_wk_irq_gate: assert property (rd_wk |->
    (readdata[7] && readdata[4]) == $past(wakeup_irq))
    else $error("wakeup irq not flag and enable");
  a_lv_irq_gate: assert property (rd_lv |->
    (readdata[7] && readdata[5] && readdata[2]) == $past(low_voltage_irq))
    else $error("lv irq gating wrong");
  a_lv_reset_gate: assert property (rd_lv |->
    (readdata[7] && readdata[4] && readdata[2]) ==
    $past(low_voltage_reset_req)) else $error("lv reset gating wrong");
  a_bgap_bit: assert property (rd_lv |->
    readdata[0] == $past(bandgap_buffer_enable)) else $error("bandgap wrong");
  a_detect_gate: assert property (rd_lv |-> (readdata[2] &&
    (!$past(stop_mode) || readdata[3])) == $past(low_voltage_detect_on))
    else $error("detect enable wrong");

  c_wk_irq: cover property ($rose(wakeup_irq));
  c_lv_rst: cover property ($rose(low_voltage_reset_req));
  c_lv_rd: cover property (rd_lv && readdata[7]);
endmodule // pwl_ctrl_sva

bind pwl_ctrl pwl_ctrl_sva u_sva (
  .ref_clk, .resetn, .address, .read, .write, .readdata, .waitrequest,
  .stop_mode, .wakeup_irq, .low_voltage_irq, .low_voltage_reset_req,
  .low_voltage_detect_on, .bandgap_buffer_enable
);

// ---- tb_top.sv ----
// self-checking bench for the wakeup timer and low-voltage register bank
`include "pwl_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 4; // shortened 1 ms tick keeps the run brief
  localparam logic [3:0] AW = `PWL_ADDR_WAKEUP;
  localparam logic [3:0] AL = `PWL_ADDR_POWER;
  localparam logic [3:0] AP = `PWL_ADDR_PENDING;
  logic        ref_clk;
  logic        resetn;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        ext_clk;
  logic        lv_evt;
  logic        stop_mode;
  logic        wk_irq;
  logic        lv_irq;
  logic        lv_rst;
  logic        det_on;
  logic        bgap;
  int          bad_count;
  int          checked;

  pwl_ctrl #(.LPO_DIV(DIV)) uut (
    .ref_clk, .resetn, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .ext_clk, .low_voltage_event(lv_evt),
    .stop_mode, .wakeup_irq(wk_irq), .low_voltage_irq(lv_irq),
    .low_voltage_reset_req(lv_rst), .low_voltage_detect_on(det_on),
    .bandgap_buffer_enable(bgap)
  );

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk(nm, {7'h0, e}, {7'h0, g});
  endtask

  // request held until waitrequest is sampled low, then one idle edge
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d,
                        input logic [3:0] be);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= 1'h1;
    @(posedge ref_clk);
    while (waitrequest !== 1'h0) @(posedge ref_clk);
    write <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a,
                        input logic [7:0] e);
    address <= a;
    read <= 1'h1;
    @(posedge ref_clk);
    while (waitrequest !== 1'h0) @(posedge ref_clk);
    chk(nm, e, readdata[7:0]);
    read <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic t_reset_vals;
    rd_chk("wk_rst", AW, 8'h00);
    rd_chk("pend_rst", AP, 8'h00);
    bus_wr(4'hc, 8'hff, 4'h1);
    rd_chk("unmapped", 4'hc, 8'h00);
    rd_chk("lv_rst_val", AL, 8'h00);
  endtask

  task automatic t_wk_internal;
    int n;
    n = 0;
    bus_wr(AW, 8'h19, 4'h1);
    while (wk_irq !== 1'h1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk_bit("wk_8ms", 1'h1, n >= 7 * DIV - 1 && n <= 8 * DIV + 4);
    rd_chk("wk_flag", AW, 8'h91);
    rd_chk("wk_pend", AP, 8'h01);
    bus_wr(AW, 8'h40, 4'h0);
    rd_chk("wk_lane_off", AW, 8'h91);
    bus_wr(AW, 8'h01, 4'h1);
    rd_chk("wk_ack0", AW, 8'h81);
    bus_wr(AW, 8'h41, 4'h1);
    rd_chk("wk_ack1", AW, 8'h01);
    repeat (40) @(posedge ref_clk);
    chk_bit("wk_masked", 1'h0, wk_irq);
    rd_chk("wk_again", AW, 8'h81);
    bus_wr(AW, 8'h50, 4'h1);
    repeat (40) @(posedge ref_clk);
    rd_chk("wk_stopped", AW, 8'h10);
  endtask

  task automatic t_wk_external;
    int n;
    n = 0;
    bus_wr(AW, 8'h31, 4'h1);
    repeat (255) begin
      ext_clk <= 1'h1;
      repeat (2) @(posedge ref_clk);
      ext_clk <= 1'h0;
      repeat (2) @(posedge ref_clk);
    end
    repeat (6) @(posedge ref_clk);
    chk_bit("ext_early", 1'h0, wk_irq);
    ext_clk <= 1'h1;
    while (wk_irq !== 1'h1 && n < 12) begin
      @(posedge ref_clk);
      n++;
    end
    chk_bit("ext_256", 1'h1, wk_irq);
    ext_clk <= 1'h0;
    bus_wr(AW, 8'h40, 4'h1);
    rd_chk("ext_clear", AW, 8'h00);
  endtask

  task automatic t_power;
    lv_evt <= 1'h1;
    repeat (6) @(posedge ref_clk);
    rd_chk("lv_off", AL, 8'h00);
    lv_evt <= 1'h0;
    repeat (4) @(posedge ref_clk);
    bus_wr(AL, 8'h37, 4'h1);
    rd_chk("lv_on", AL, 8'h35);
    chk_bit("bgap_on", 1'h1, bgap);
    stop_mode <= 1'h1;
    @(posedge ref_clk);
    chk_bit("det_stop", 1'h0, det_on);
    stop_mode <= 1'h0;
    lv_evt <= 1'h1;
    repeat (6) @(posedge ref_clk);
    chk_bit("lv_irq", 1'h1, lv_irq);
    chk_bit("lv_rst", 1'h1, lv_rst);
    rd_chk("lv_flag", AL, 8'hb5);
    lv_evt <= 1'h0;
    repeat (4) @(posedge ref_clk);
    bus_wr(AL, 8'h48, 4'h1);
    rd_chk("lv_once", AL, 8'h1c);
    chk_bit("lv_rst_off", 1'h0, lv_rst);
    chk_bit("bgap_off", 1'h0, bgap);
    stop_mode <= 1'h1;
    @(posedge ref_clk);
    chk_bit("det_keep", 1'h1, det_on);
    stop_mode <= 1'h0;
    resetn <= 1'h0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'h1;
    @(posedge ref_clk);
    bus_wr(AL, 8'h04, 4'h1);
    rd_chk("lv_reopen", AL, 8'h04);
  endtask

  // watchdog: all scenarios need about 1250 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    test_done;
  end

  initial begin
    bad_count = 0;
    checked = 0;
    resetn = 1'h0;
    address = 4'h0;
    read = 1'h0;
    write = 1'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    ext_clk = 1'h0;
    lv_evt = 1'h0;
    stop_mode = 1'h0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'h1;
    @(posedge ref_clk);
    t_reset_vals;
    t_wk_internal;
    t_wk_external;
    t_power;
    test_done;
  end
endmodule // tb_top
